// [hw/fns_synth_top.v]
// Top of the synthesizer control logic: serial programming port, word
// decode, temporary and working registers, main divider with fractional
// accumulator, and the reference divider instance.
// Assumes serial pins, the prescaler output and the reference input are
// asynchronous to refClk and much slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "fns_regs.vh"
module fns_synth_top (
  input wire ref_clk, // 100 MHz system clock.
  input wire rst_n, // Asynchronous reset, active low.
  input wire serClk, // Serial clock pin.
  input wire serData, // Serial data pin.
  input wire serStrobe, // Serial strobe pin.
  input wire prescalerOut, // Prescaler output, one period per count.
  input wire refIn, // Reference input pin.
  output reg [1:0] modulusFeedback_r, // Prescaler ratio select code.
  output reg mainPulse_r, // Main divider pulse to phase detector.
  output reg refPulse_r, // Reference pulse to phase detector.
  output reg [7:0] pumpCurrentFactor_r, // Charge pump current factor.
  output reg [2:0] fractionAccumValue_r, // Fractional accumulator value.
  output reg synthOnBit_r, // Prescaler and reference stage enable.
  output reg [1:0] testBits_r // Test word contents.
);

  localparam [1:0] ST_64 = 2'h0; // Sync stage, counts down.
  localparam [1:0] ST_65 = 2'h1; // Modulus-65 stage, counts up.
  localparam [1:0] ST_68 = 2'h2; // Modulus-68 stage, counts up.
  localparam [1:0] ST_73 = 2'h3; // Modulus-73 stage, counts up.

  reg [1:0] rstSync_r; // Reset release chain.
  wire rst; // Internal reset, active high.
  reg [2:0] clkSync_r; // Serial clock sync plus edge history.
  reg [1:0] dataSync_r; // Serial data sync.
  reg [2:0] strbSync_r; // Strobe sync plus edge history.
  reg [2:0] presSync_r; // Prescaler output sync plus edge history.
  reg [2:0] refSync_r; // Reference input sync plus edge history.
  reg [31:0] shift_r; // Serial shift register.
  reg [5:0] bitCnt_r; // Bits shifted since last strobe, saturating.
  reg [2:0] holdNf_r; // Pending main word fraction step.
  reg [11:0] holdNm1_r; // Pending modulus-64 count.
  reg [7:0] holdNm23_r; // Pending modulus-65/68 counts.
  reg [7:0] holdCn_r; // Pending pump factor.
  reg pending_r; // A main word awaits the sync window.
  reg [7:0] tmpCn_r; // Pump factor temporary.
  reg [1:0] tmpPr_r; // Modulus set temporary.
  reg [3:0] tmpNm4_r; // Modulus-73 count temporary.
  reg longFmt_r; // Main word format flag.
  reg fracBase_r; // Fraction base select.
  reg [11:0] refRatio_r; // Reference divide ratio.
  reg [1:0] tapSel_r; // Reference output tap.
  reg [11:0] wkNm1_r; // Working modulus-64 count.
  reg [7:0] wkNm23_r; // Working modulus-65/68 counts.
  reg [3:0] wkNm4_r; // Working modulus-73 count.
  reg [1:0] wkPr_r; // Working modulus set.
  reg [2:0] wkNf_r; // Working fraction step.
  reg [1:0] stage_r; // Main divider stage.
  reg [12:0] cnt_r; // Main counter with sign bit.
  reg carry_r; // Accumulator overflow owed to the next cycle.
  reg [1:0] stage_nxt; // Stage after the current one ends.
  reg [12:0] target; // Up-count end value for the current stage.
  reg [12:0] cntStart; // Counter load for the next stage.
  reg [3:0] accSum; // Accumulator plus step.
  reg [3:0] qVal; // Current fractional modulus.
  reg stageDone; // Current stage ends on this prescaler pulse.
  wire [3:0] wkNm2; // Modulus-65 count for the working set.
  wire [3:0] wkNm3; // Modulus-68 count for the working set.
  wire [7:0] nm2Full; // Modulus-65 count, 4 or 8 bits wide.
  wire en68; // Modulus-68 stage enabled.
  wire en73; // Modulus-73 stage enabled.
  wire serRise; // Serial clock rising edge.
  wire strbRise; // Strobe rising edge.
  wire strbFall; // Strobe falling edge.
  wire presEdge; // Counted prescaler period.
  wire refEdge; // Counted reference edge.
  wire syncActive; // Main word load window.
  wire [3:0] addr4; // Four-bit address of a short word.
  wire refPulse; // Reference divider output.

  // Release the asynchronous reset through two flip-flops.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rst = ~rstSync_r[1];

  // Two-stage synchronisers; the third stage only serves edge detection.
  always @(posedge ref_clk) begin
    if (rst) begin
      clkSync_r <= 3'h0;
      dataSync_r <= 2'h0;
      strbSync_r <= 3'h0;
      presSync_r <= 3'h0;
      refSync_r <= 3'h0;
    end else begin
      clkSync_r <= {clkSync_r[1:0], serClk};
      dataSync_r <= {dataSync_r[0], serData};
      strbSync_r <= {strbSync_r[1:0], serStrobe};
      presSync_r <= {presSync_r[1:0], prescalerOut};
      refSync_r <= {refSync_r[1:0], refIn};
    end
  end

  assign serRise = clkSync_r[1] & ~clkSync_r[2];
  assign strbRise = strbSync_r[1] & ~strbSync_r[2];
  assign strbFall = ~strbSync_r[1] & strbSync_r[2];
  assign presEdge = presSync_r[1] & ~presSync_r[2] & synthOnBit_r;
  assign refEdge = refSync_r[1] & ~refSync_r[2] & synthOnBit_r;
  assign addr4 = shift_r[3:0];

  assign en68 = wkPr_r[1];
  assign en73 = (wkPr_r == 2'h3) || (wkPr_r == 2'h0);
  assign wkNm2 = wkNm23_r[3:0];
  assign wkNm3 = wkNm23_r[7:4];
  assign nm2Full = en68 ? {4'h0, wkNm2} : wkNm23_r;
  assign syncActive = (stage_r == ST_64);

  // Serial port: shift, then decode and route the word at the strobe.
  always @(posedge ref_clk) begin
    if (rst) begin
      shift_r <= 32'h0;
      bitCnt_r <= 6'h0;
      pending_r <= 1'b0;
      holdNf_r <= 3'h0;
      holdNm1_r <= `FNS_RST_NM1;
      holdNm23_r <= `FNS_RST_NM23;
      holdCn_r <= `FNS_RST_CN;
      tmpCn_r <= `FNS_RST_CN;
      tmpPr_r <= `FNS_RST_PR;
      tmpNm4_r <= `FNS_RST_NM4;
      longFmt_r <= 1'b0;
      fracBase_r <= 1'b0;
      synthOnBit_r <= 1'b0;
      testBits_r <= 2'h0;
      refRatio_r <= `FNS_RST_NR;
      tapSel_r <= 2'h0;
    end else begin
      if (serRise && !strbSync_r[1]) begin
        shift_r <= {shift_r[30:0], dataSync_r[1]};
        if (bitCnt_r != 6'h3F) begin
          bitCnt_r <= bitCnt_r + 6'h01;
        end
      end
      // A strobe that ends before the window drops the pending main word.
      if (strbFall) begin
        pending_r <= 1'b0;
      end
      if (strbRise) begin
        bitCnt_r <= 6'h0;
        if (!shift_r[0]) begin
          if ((bitCnt_r == `FNS_LEN_LONG && longFmt_r) ||
              (bitCnt_r == `FNS_LEN_SHORT && !longFmt_r)) begin
            pending_r <= 1'b1;
            holdNm23_r <= shift_r[`FNS_A_NM23_LSB +: 8];
            holdNm1_r <= shift_r[`FNS_A_NM1_LSB +: 12];
            holdNf_r <= shift_r[`FNS_A_NF_LSB +: 3];
            holdCn_r <= longFmt_r ? shift_r[`FNS_A_CN_LSB +: 8] : tmpCn_r;
          end
        end else if (bitCnt_r == `FNS_LEN_SHORT) begin
          case (addr4)
            `FNS_ADDR_CTRL: begin
              tmpCn_r <= shift_r[`FNS_B_CN_LSB +: 8];
              tmpPr_r <= shift_r[`FNS_B_PR_LSB +: 2];
              tmpNm4_r <= shift_r[`FNS_B_NM4_LSB +: 4];
            end
            `FNS_ADDR_SETUP: begin
              synthOnBit_r <= shift_r[`FNS_D_EM_BIT];
              longFmt_r <= shift_r[`FNS_D_LONG_BIT];
              fracBase_r <= shift_r[`FNS_D_FRACTION_BASE_SELECT_BIT];
              testBits_r <= 2'h0;
            end
            `FNS_ADDR_REF: begin
              refRatio_r <= shift_r[`FNS_C_NR_LSB +: 12];
              tapSel_r <= shift_r[`FNS_C_SM_LSB +: 2];
            end
            `FNS_ADDR_TEST: begin
              testBits_r <= shift_r[`FNS_E_T_LSB +: 2];
            end
            default: begin
              // Unknown addresses are ignored.
            end
          endcase
        end
      end else if (pending_r && syncActive && strbSync_r[1]) begin
        pending_r <= 1'b0;
      end
    end
  end

  // Pick the next enabled stage and its counter load.
  always @* begin
    case (stage_r)
      ST_64: stage_nxt = (nm2Full != 8'h00) ? ST_65 : en68 ? ST_68 : en73 ? ST_73 : ST_64;
      ST_65: stage_nxt = en68 ? ST_68 : en73 ? ST_73 : ST_64;
      ST_68: stage_nxt = en73 ? ST_73 : ST_64;
      default: stage_nxt = ST_64;
    endcase
    case (stage_r)
      ST_65: target = {5'h00, nm2Full};
      ST_68: target = {9'h000, wkNm3} + 13'h0001;
      ST_73: target = {9'h000, wkNm4_r} + 13'h0001;
      default: target = 13'h0000;
    endcase
    if (stage_nxt == ST_64) begin
      cntStart = {1'b0, wkNm1_r} + 13'h0001;
    end else begin
      cntStart = 13'h0001;
    end
    if (stage_r == ST_64) begin
      stageDone = cnt_r[12] == 1'b0 && cnt_r == 13'h0000;
    end else begin
      stageDone = (cnt_r >= target);
    end
    qVal = fracBase_r ? `FNS_Q_EIGHT : `FNS_Q_FIVE;
    accSum = {1'b0, fractionAccumValue_r} + {1'b0, wkNf_r};
  end

  // Main divider, working registers and fractional accumulator.
  always @(posedge ref_clk) begin
    if (rst) begin
      stage_r <= ST_64;
      cnt_r <= {1'b0, `FNS_RST_NM1} + 13'h0001;
      carry_r <= 1'b0;
      mainPulse_r <= 1'b0;
      modulusFeedback_r <= `FNS_FB_64;
      fractionAccumValue_r <= 3'h0;
      wkNm1_r <= `FNS_RST_NM1;
      wkNm23_r <= `FNS_RST_NM23;
      wkNm4_r <= `FNS_RST_NM4;
      wkPr_r <= `FNS_RST_PR;
      wkNf_r <= 3'h0;
      pumpCurrentFactor_r <= `FNS_RST_CN;
    end else begin
      mainPulse_r <= 1'b0;
      // load in sync window. modulus set and modulus-73 temporaries move too.
      if (pending_r && syncActive && strbSync_r[1] && !strbRise) begin
        wkNm1_r <= holdNm1_r;
        wkNm23_r <= holdNm23_r;
        wkNf_r <= holdNf_r;
        wkPr_r <= tmpPr_r;
        wkNm4_r <= tmpNm4_r;
        pumpCurrentFactor_r <= holdCn_r;
      end
      if (presEdge) begin
        if (stage_r == ST_64 && carry_r) begin
          carry_r <= 1'b0;
        end
        if (stageDone) begin
          stage_r <= stage_nxt;
          cnt_r <= cntStart;
          if (stage_r == ST_64) begin
            mainPulse_r <= 1'b1;
            if (accSum >= qVal) begin
              fractionAccumValue_r <= accSum[2:0] - qVal[2:0];
              carry_r <= 1'b1;
            end else begin
              fractionAccumValue_r <= accSum[2:0];
            end
          end
        end else if (stage_r == ST_64) begin
          cnt_r <= cnt_r - 13'h0001;
        end else begin
          cnt_r <= cnt_r + 13'h0001;
        end
      end
      case (stage_r)
        ST_64: modulusFeedback_r <= carry_r ? `FNS_FB_65 : `FNS_FB_64;
        ST_65: modulusFeedback_r <= `FNS_FB_65;
        ST_68: modulusFeedback_r <= `FNS_FB_68;
        default: modulusFeedback_r <= `FNS_FB_73;
      endcase
    end
  end

  // Reference chain; its pulse is registered again for a clean output.
  fns_ref_div refDiv (
    .clk(ref_clk),
    .rst(rst),
    .refEdge(refEdge),
    .refRatio(refRatio_r),
    .outputTapSelect(tapSel_r),
    .refPulse_r(refPulse)
  );

  // Reference pulse retimed here so the output comes from a flip-flop.
  always @(posedge ref_clk) begin
    if (rst) begin
      refPulse_r <= 1'b0;
    end else begin
      refPulse_r <= refPulse;
    end
  end

endmodule
`default_nettype wire

// [hw/fns_regs.vh]
// Constants for the fractional-N synthesizer control logic: word formats,
// field positions, reset values and divider codes.
// Assumes it is included by bare name from the design files under hw/.
`ifndef FNS_REGS_VH
`define FNS_REGS_VH

// Word lengths in bits.
`define FNS_LEN_SHORT 6'h18
`define FNS_LEN_LONG 6'h20

// Four-bit addresses of the non-main words (main word has bit 0 clear).
`define FNS_ADDR_CTRL 4'h1
`define FNS_ADDR_SETUP 4'h3
`define FNS_ADDR_REF 4'h5
`define FNS_ADDR_TEST 4'h7

// Main word fields.
`define FNS_A_NM23_LSB 1
`define FNS_A_NM1_LSB 9
`define FNS_A_NF_LSB 21
`define FNS_A_CN_LSB 24

// Control word fields.
`define FNS_B_NM4_LSB 10
`define FNS_B_PR_LSB 14
`define FNS_B_CN_LSB 16

// Reference word fields.
`define FNS_C_NR_LSB 4
`define FNS_C_SM_LSB 16

// Setup word bits.
`define FNS_D_EM_BIT 4
`define FNS_D_LONG_BIT 5
`define FNS_D_FRACTION_BASE_SELECT_BIT 6

// Test word field.
`define FNS_E_T_LSB 4

// Reset values.
`define FNS_RST_NR 12'h004
`define FNS_RST_PR 2'h1
`define FNS_RST_NM1 12'h010
`define FNS_RST_NM23 8'h00
`define FNS_RST_NM4 4'h0
`define FNS_RST_CN 8'h00

// Fractional modulus values.
`define FNS_Q_EIGHT 4'h8
`define FNS_Q_FIVE 4'h5

// Prescaler feedback codes.
`define FNS_FB_64 2'h0
`define FNS_FB_65 2'h1
`define FNS_FB_68 2'h2
`define FNS_FB_73 2'h3

`endif

// [hw/fns_ref_div.v]
// Reference divider: programmable divide by ratio followed by a 3-bit
// binary counter whose tap picks the output pulse.
// Assumes refEdge is a one-cycle pulse already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module fns_ref_div (
  input wire clk, // System clock.
  input wire rst, // Synchronous-release reset, active high.
  input wire refEdge, // One pulse per reference input rising edge.
  input wire [11:0] refRatio, // Divide ratio, 4 to 4095.
  input wire [1:0] outputTapSelect, // Extra division code.
  output reg refPulse_r // One-cycle pulse to the phase detector.
);

  reg [11:0] divCnt_r; // Counts reference edges up to the ratio.
  reg [2:0] octCnt_r; // Binary counter after the divider.
  reg [2:0] tapMask; // Low counter bits that must roll over.
  wire [2:0] octNxt; // Counter value after this divider pulse.

  assign octNxt = octCnt_r + 3'h1;

  always @* begin
    case (outputTapSelect)
      2'h0: tapMask = 3'h0;
      2'h1: tapMask = 3'h1;
      2'h2: tapMask = 3'h3;
      default: tapMask = 3'h7;
    endcase
  end

  // Divider and binary counter; the pulse fires when the tapped bits roll.
  always @(posedge clk) begin
    if (rst) begin
      divCnt_r <= 12'h001;
      octCnt_r <= 3'h0;
      refPulse_r <= 1'b0;
    end else begin
      refPulse_r <= 1'b0;
      if (refEdge) begin
        if (divCnt_r >= refRatio) begin
          divCnt_r <= 12'h001;
          octCnt_r <= octNxt;
          refPulse_r <= ((octNxt & tapMask) == 3'h0);
        end else begin
          divCnt_r <= divCnt_r + 12'h001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/fns_synth_top_properties.sv]
// Checker for the synthesizer control top: pulses, accumulator and config timing.
// Assumes it is bound to fns_synth_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fns_synth_props (
  input wire logic ref_clk, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic serClk, // Serial clock pin.
  input wire logic serData, // Serial data pin.
  input wire logic serStrobe, // Strobe pin.
  input wire logic prescalerOut, // Prescaler output.
  input wire logic refIn, // Reference input.
  input wire logic [1:0] modulusFeedback_r, // Ratio select.
  input wire logic mainPulse_r, // Main pulse.
  input wire logic refPulse_r, // Reference pulse.
  input wire logic [7:0] pumpCurrentFactor_r, // Pump factor.
  input wire logic [2:0] fractionAccumValue_r, // Accumulator.
  input wire logic synthOnBit_r, // Enable bit.
  input wire logic [1:0] testBits_r // Test bits.
);
  // All checks run on the system clock and rest while reset is low.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_main_pulse_single: assert property (mainPulse_r |=> !mainPulse_r)
    else $error("main pulse wider than one cycle");
  a_ref_pulse_single: assert property (refPulse_r |=> !refPulse_r)
    else $error("reference pulse wider than one cycle");
  a_acc_on_pulse: assert property ($changed(fractionAccumValue_r) |->
    (mainPulse_r || $past(mainPulse_r))) else $error("accumulator moved without a pulse");
  a_off_no_pulse: assert property (!synthOnBit_r && !$past(synthOnBit_r, 6) |->
    !mainPulse_r && !refPulse_r) else $error("pulse while disabled");
  a_fb_frozen_off: assert property (!synthOnBit_r && !$past(synthOnBit_r, 4) |->
    $stable(modulusFeedback_r)) else $error("feedback moved while disabled");
  a_pump_on_strobe: assert property ($changed(pumpCurrentFactor_r) |->
    $past(serStrobe, 3)) else $error("pump factor changed without strobe");
  a_enable_on_strobe: assert property ($changed(synthOnBit_r) |->
    $past(serStrobe, 3)) else $error("enable changed without strobe");
  a_test_on_strobe: assert property ($changed(testBits_r) |->
    $past(serStrobe, 3)) else $error("test bits changed without strobe");
endmodule
bind fns_synth_top fns_synth_props chk (.ref_clk(ref_clk), .rst_n(rst_n), .serClk(serClk),
  .serData(serData), .serStrobe(serStrobe), .prescalerOut(prescalerOut), .refIn(refIn),
  .modulusFeedback_r(modulusFeedback_r), .mainPulse_r(mainPulse_r), .refPulse_r(refPulse_r),
  .pumpCurrentFactor_r(pumpCurrentFactor_r), .fractionAccumValue_r(fractionAccumValue_r),
  .synthOnBit_r(synthOnBit_r), .testBits_r(testBits_r));
`default_nettype wire

// [testbench/fns_host_model.sv]
// Host model: drives the three-wire programming port, most significant bit first.
// Assumes the bench calls send only between frames.
`timescale 1ns/1ps
`default_nettype none
module fns_host_model (
  output var logic serClk, // Serial clock, still between frames.
  output var logic serData, // Serial data.
  output var logic serStrobe // Load strobe.
);
  // Idle levels at time zero.
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    serStrobe = 1'b0;
  end
  // Sends one word with a 125 ns serial clock, then pulses the strobe.
  task automatic send(input logic [31:0] w, input logic isLong, input int holdNs);
    int n;
    n = isLong ? 32 : 24;
    for (int i = n - 1; i >= 0; i--) begin
      serData = w[i];
      #31 serClk = 1'b1;
      #62.5 serClk = 1'b0;
      #31.5;
    end
    // strobe held through the load window
    serStrobe = 1'b1;
    #(holdNs) serStrobe = 1'b0;
    serData = ~serData;
    #200;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_fns_synth_top.sv]
// Self-checking bench for the synthesizer control top with a host model.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "fns_regs.vh"
module tb_fns_synth_top;
  logic refClk = 1'b0; // System clock.
  logic rstN = 1'b0; // Reset, active low.
  logic presc = 1'b0; // Prescaler output model.
  logic refIn = 1'b0; // Reference input model.
  logic [3:0] pc = 4'h0; // Prescaler phase.
  logic [1:0] refCnt = 2'h0; // Reference phase.
  logic [31:0] lfsr = 32'h7997; // Random state.
  logic [7:0] pumpExp = 8'h00; // Expected pump factor.
  wire logic serClk, serData, serStrobe, mainP, refP, synthOn;
  wire logic [1:0] fb, testB;
  wire logic [7:0] pump;
  wire logic [2:0] acc;
  int fails = 0;
  int comparisons = 0;
  int runSum = 0;
  int lastSum = 0;
  always #5 refClk = ~refClk;
  fns_host_model host (.serClk(serClk), .serData(serData), .serStrobe(serStrobe));
  fns_synth_top uut (.ref_clk(refClk), .rst_n(rstN), .serClk(serClk), .serData(serData),
    .serStrobe(serStrobe), .prescalerOut(presc), .refIn(refIn), .modulusFeedback_r(fb),
    .mainPulse_r(mainP), .refPulse_r(refP), .pumpCurrentFactor_r(pump),
    .fractionAccumValue_r(acc), .synthOnBit_r(synthOn), .testBits_r(testB));
  // Prescaler ratio that a feedback code asks for.
  function automatic int ratio(input logic [1:0] c);
    return (c == 2'h0) ? 64 : (c == 2'h1) ? 65 : (c == 2'h2) ? 68 : 73;
  endfunction
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Prescaler of 10 cycles a period, reference of 4; sums VCO counts per main cycle.
  always @(posedge refClk) begin
    pc <= (pc == 4'h9) ? 4'h0 : pc + 4'h1;
    refCnt <= refCnt + 2'h1;
    refIn <= refCnt[1];
    if (pc == 4'h9) begin
      presc <= 1'b1;
    end else if (pc == 4'h4) begin
      presc <= 1'b0;
    end
    if (mainP === 1'b1) begin
      lastSum <= runSum + ((pc == 4'h9) ? ratio(fb) : 0);
      runSum <= 0;
    end else begin
      runSum <= runSum + ((pc == 4'h9) ? ratio(fb) : 0);
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic rnd;
    lfsr = nextRand(lfsr);
  endtask
  // Waits for a main or reference pulse; cyc is the cycles taken.
  task automatic waitFor(input logic useRef, output int cyc);
    for (cyc = 1; cyc <= 20000; cyc++) begin
      @(negedge refClk);
      if ((useRef ? refP : mainP) === 1'b1) begin
        return;
      end
    end
    fails++;
    $display("Error pulse expected 1 seen 0");
    tally_and_finish;
  endtask
  // Programs setup, control and main words, then measures division and fraction.
  task automatic runCase(input logic [1:0] pr, input logic fraction_base_select, input logic lng);
    logic [7:0] nm23, cnT, cnL;
    logic [11:0] nm1;
    logic [3:0] nm4;
    logic [2:0] nf;
    int n, q, accPrev, carry, cyc;
    rnd;
    nm1 = {8'h00, lfsr[3:0]};
    nm23 = lfsr[11:4] & 8'h37;
    nm4 = {2'h0, lfsr[13:12]};
    // A step at or above the modulus has no meaning, so keep it below Q.
    nf = fraction_base_select ? lfsr[16:14] : lfsr[16:14] % 3'h5;
    cnT = lfsr[23:16];
    cnL = cnT ^ 8'hA5;
    q = fraction_base_select ? 8 : 5;
    n = (nm1 + 2) * 64 + (pr[1] ? nm23[3:0] : nm23) * 65 + (pr[1] ? (nm23[7:4] + 1) * 68 : 0)
      + ((pr == 2'h3 || pr == 2'h0) ? (nm4 + 1) * 73 : 0);
    host.send({17'h0, fraction_base_select, lng, 1'b1, `FNS_ADDR_SETUP}, 1'b0, 100);
    check("test bits", testB, 2'h0);
    check("enable", synthOn, 1'b1);
    host.send({cnT, pr, nm4, 6'h00, `FNS_ADDR_CTRL}, 1'b0, 100);
    check("pump held", pump, pumpExp);
    host.send({cnL, nf, nm1, nm23, 1'b0}, lng, 9000);
    pumpExp = lng ? cnL : cnT;
    check("pump", pump, pumpExp);
    waitFor(1'b0, cyc);
    waitFor(1'b0, cyc);
    @(negedge refClk);
    @(negedge refClk);
    accPrev = acc;
    carry = 0;
    for (int k = 0; k < 4; k++) begin
      waitFor(1'b0, cyc);
      @(negedge refClk);
      @(negedge refClk);
      if (k > 0) check("division", lastSum, n + carry);
      carry = (accPrev + nf >= q);
      accPrev = (accPrev + nf) % q;
      check("accumulator", acc, accPrev);
    end
    $display("test modulus set %0d done", pr);
  endtask
  // Main sequence.
  initial begin
    int nr, cyc;
    repeat (6) @(posedge refClk);
    rstN <= 1'b1;
    repeat (8) @(posedge refClk);
    @(negedge refClk);
    check("feedback", fb, 2'h0);
    check("enable", synthOn, 1'b0);
    rnd;
    host.send({18'h0, lfsr[1:0] | 2'h1, `FNS_ADDR_TEST}, 1'b0, 100);
    check("test bits", testB, lfsr[1:0] | 2'h1);
    $display("test reset and test word done");
    runCase(2'h1, 1'b0, 1'b0);
    runCase(2'h2, 1'b0, 1'b1);
    runCase(2'h3, 1'b1, 1'b0);
    runCase(2'h0, 1'b1, 1'b1);
    // A short main word while the long format is selected must be refused.
    host.send(32'h00000000, 1'b0, 9000);
    check("pump refused", pump, pumpExp);
    $display("test refused word done");
    for (int s = 0; s < 4; s++) begin
      rnd;
      nr = 4 + lfsr[2:0];
      host.send({6'h00, s[1:0], nr[11:0], `FNS_ADDR_REF}, 1'b0, 100);
      waitFor(1'b1, cyc);
      waitFor(1'b1, cyc);
      waitFor(1'b1, cyc);
      check("ref interval", cyc, 4 * nr * (1 << s));
      $display("test reference tap %0d done", s);
    end
    // Switch the synthesizer off with both dividers busy; no pulse may follow.
    host.send({17'h0, 1'b0, 1'b0, 1'b0, `FNS_ADDR_SETUP}, 1'b0, 100);
    check("enable off", synthOn, 1'b0);
    cyc = 0;
    repeat (8000) begin
      @(negedge refClk);
      if (mainP !== 1'b0 || refP !== 1'b0) begin
        cyc++;
      end
    end
    check("pulses while off", cyc, 0);
    $display("test disable done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
